// *** logic/asp_pkg.sv ***
// Package of constants for the converter serial pin interface
package asp_pkg;
    localparam int CMD_BITS = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] BIT_CNT_RST = 3'h0;
    localparam logic [CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_MODE_HI = 5;
    localparam int CLK_MODE_LO = 4;
    localparam logic [7:0] SETUP_RST = 8'h20;
    localparam logic [7:0] SETUP_TAG_MASK = 8'hc0;
    localparam logic [7:0] SETUP_TAG = 8'h40;
    localparam logic [1:0] SETUP_REF_HI = 2'h3;
    localparam int REFSEL_HI = 3;
    localparam int REFSEL_LO = 2;
    typedef enum logic [1:0] {
        ASP_CK_CONV_INT = 2'b00,
        ASP_CK_CONV_ONE = 2'b01,
        ASP_CK_SERIAL = 2'b10,
        ASP_CK_EXT = 2'b11
    } asp_ckmode_e;
endpackage : asp_pkg

// *** logic/asp_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module asp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    // Valid sits in its own flop so the consumer sees a registered signal
    logic valid_r;
    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = valid_r;
    assign out_data_o = mem_r[rd_ptr_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            valid_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            valid_r <= (count_nxt != '0);
        end
    end
endmodule : asp_fifo

// *** logic/asp_serial_if.sv ***
// Device-side serial pin interface of a multichannel converter
`timescale 1ns/100ps
module asp_serial_if
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    input wire logic convert_request_n_i,
    output logic eoc_n_o,
    output logic [DATA_W-1:0] cmd_data_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic [1:0] clock_mode_select_o,
    output logic start_pin_is_analog_o,
    output logic ref_neg_is_analog_o,
    output logic overrun_o
);
    // Synchronisers for all pins: three stages for select, clock and request, two for data
    logic [2:0] cs_sync_r;
    logic [2:0] sclk_sync_r;
    logic [1:0] din_sync_r;
    logic [2:0] cnv_sync_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cs_sync_r <= 3'h7;
            sclk_sync_r <= 3'h0;
            din_sync_r <= 2'h0;
            cnv_sync_r <= 3'h7;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
            din_sync_r <= {din_sync_r[0], din_i};
            cnv_sync_r <= {cnv_sync_r[1:0], convert_request_n_i};
        end
    end

    // Only stages 1 and 2 feed logic; stage 0 is the metastable catcher
    wire cs_n_s = cs_sync_r[1];
    wire cs_fall = cs_sync_r[2] && !cs_sync_r[1];
    wire sclk_rise = !sclk_sync_r[2] && sclk_sync_r[1];
    wire sclk_fall = sclk_sync_r[2] && !sclk_sync_r[1];
    wire din_s = din_sync_r[1];
    wire cnv_fall = cnv_sync_r[2] && !cnv_sync_r[1];
    wire sample_en = !cs_n_s && sclk_rise;
    wire shift_en = !cs_n_s && sclk_fall;

    logic [CNT_W-1:0] bit_cnt_r;
    logic [DATA_W-1:0] shreg_r;
    logic [DATA_W-1:0] txsh_r;
    logic first_byte_r;
    logic [7:0] setup_r;
    logic [DATA_W-1:0] cmd_data_r;
    logic cmd_valid_r;
    logic overrun_r;
    logic dout_r;
    logic dout_oe_n_r;
    logic eoc_n_r;
    logic conv_start_r;
    // Pin-use flags live in their own flops so the outputs are registered
    logic start_ana_r;
    logic ref_ana_r;

    wire byte_done = sample_en && (bit_cnt_r == BIT_CNT_LAST);
    wire [DATA_W-1:0] rx_byte = {shreg_r[DATA_W-2:0], din_s};
    wire is_setup = (rx_byte & SETUP_TAG_MASK) == SETUP_TAG;
    wire [1:0] mode_w = setup_r[CLK_MODE_HI:CLK_MODE_LO];
    wire mode_ext = (mode_w == 2'(ASP_CK_EXT));
    wire start_pin_active = (mode_w == 2'(ASP_CK_CONV_INT)) ||
        (mode_w == 2'(ASP_CK_CONV_ONE));
    wire byte_stalled = cmd_valid_r && !cmd_ready_i;

    // Receive shifter, MSB first; counter restarts whenever select is high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || cs_n_s) begin
            bit_cnt_r <= BIT_CNT_RST;
            shreg_r <= '0;
        end else if (sample_en) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            shreg_r <= rx_byte;
        end
    end

    // Command byte and setup capture
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            first_byte_r <= 1'b1;
            setup_r <= SETUP_RST;
            start_ana_r <= SETUP_RST[CLK_MODE_HI];
            ref_ana_r <= (SETUP_RST[REFSEL_HI:REFSEL_LO] != SETUP_REF_HI);
            cmd_data_r <= '0;
            cmd_valid_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (cs_n_s) begin
                first_byte_r <= 1'b1;
            end else if (byte_done) begin
                first_byte_r <= 1'b0;
            end
            if (byte_done && first_byte_r && is_setup) begin
                setup_r <= rx_byte;
                // Start pin is a request only in modes 00 and 01, i.e. mode bit 1 low
                start_ana_r <= rx_byte[CLK_MODE_HI];
                ref_ana_r <= (rx_byte[REFSEL_HI:REFSEL_LO] != SETUP_REF_HI);
            end
            if (byte_done && !byte_stalled) begin
                cmd_data_r <= rx_byte;
                cmd_valid_r <= 1'b1;
            end else if (cmd_ready_i) begin
                cmd_valid_r <= 1'b0;
            end
            // Back-pressure cannot stop the host clock, so a dropped byte is flagged
            overrun_r <= byte_done && byte_stalled;
        end
    end

    // Transmit shifter: loads at select fall, shifts on falling clock edges
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            txsh_r <= '0;
            dout_r <= 1'b0;
            dout_oe_n_r <= 1'b1;
        end else begin
            dout_oe_n_r <= cs_n_s;
            if (cs_fall) begin
                txsh_r <= tx_data_i;
                dout_r <= tx_data_i[DATA_W-1];
            end else if (shift_en) begin
                txsh_r <= {txsh_r[DATA_W-2:0], 1'b0};
                dout_r <= txsh_r[DATA_W-2];
            end
        end
    end

    // End of conversion and start requests
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eoc_n_r <= 1'b1;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= start_pin_active && cnv_fall;
            if (mode_ext) begin
                eoc_n_r <= 1'b1;
            end else if (conv_done_i) begin
                eoc_n_r <= 1'b0;
            end else if (cs_fall || (start_pin_active && cnv_fall)) begin
                eoc_n_r <= 1'b1;
            end
        end
    end

    assign dout_o = dout_r;
    assign dout_oe_n_o = dout_oe_n_r;
    assign eoc_n_o = eoc_n_r;
    assign cmd_data_o = cmd_data_r;
    assign cmd_valid_o = cmd_valid_r;
    assign conv_start_o = conv_start_r;
    assign clock_mode_select_o = setup_r[CLK_MODE_HI:CLK_MODE_LO];
    assign start_pin_is_analog_o = start_ana_r;
    assign ref_neg_is_analog_o = ref_ana_r;
    assign overrun_o = overrun_r;
endmodule : asp_serial_if

// *** logic/asp_top.sv ***
// Top level: serial pin interface feeding the command FIFO
`timescale 1ns/100ps
module asp_top
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    input wire logic convert_request_n_i,
    output logic eoc_n_o,
    input wire logic [DATA_W-1:0] tx_data_i,
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic [1:0] clock_mode_select_o,
    output logic start_pin_is_analog_o,
    output logic ref_neg_is_analog_o,
    output logic overrun_o,
    output logic [DATA_W-1:0] cmd_data_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i
);
    logic [DATA_W-1:0] if_data;
    logic if_valid;
    logic if_ready;
    asp_serial_if u_if (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
        .din_i(din_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o),
        .convert_request_n_i(convert_request_n_i), .eoc_n_o(eoc_n_o),
        .cmd_data_o(if_data), .cmd_valid_o(if_valid), .cmd_ready_i(if_ready),
        .tx_data_i(tx_data_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
        .clock_mode_select_o(clock_mode_select_o),
        .start_pin_is_analog_o(start_pin_is_analog_o),
        .ref_neg_is_analog_o(ref_neg_is_analog_o), .overrun_o(overrun_o)
    );
    asp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .in_data_i(if_data), .in_valid_i(if_valid), .in_ready_o(if_ready),
        .out_data_o(cmd_data_o), .out_valid_o(cmd_valid_o), .out_ready_i(cmd_ready_i)
    );
endmodule : asp_top

// *** sim/asp_host_model.sv ***
// Host serial master model driving the converter pins
`timescale 1ns/100ps
module asp_host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o,
    input wire logic dout_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    // Offset keeps pin edges clear of clk_i edges when called on a clk_i edge; n below 8 leaves a byte unfinished
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        #3 cs_n_o = 1'b0;
        #200;
        for (int i = 7; i > 7 - n; i--) begin
            din_o = tx[i];
            #40 sclk_o = 1'b1;
            #40 rx[i] = dout_i;
            sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        din_o = ~din_o;
        #200;
    endtask : xfer
endmodule : asp_host_model

// *** sim/asp_top_checker.sv ***
// Assertion checker for the converter serial pin top level
`timescale 1ns/100ps
module asp_top_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic conv_done_i,
    input wire logic dout_oe_n_o,
    input wire logic eoc_n_o,
    input wire logic conv_start_o,
    input wire logic [1:0] clock_mode_select_o,
    input wire logic start_pin_is_analog_o,
    input wire logic cmd_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_oe_off; cs_n_i [*6] |-> dout_oe_n_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout enabled");
    property p_oe_on; !cs_n_i [*6] |-> !dout_oe_n_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout released");
    property p_eoc_set; conv_done_i && clock_mode_select_o != 2'h3 |=> !eoc_n_o; endproperty
    a_eoc_set: assert property (p_eoc_set) else $error("eoc not low");
    property p_eoc_ext; conv_done_i && clock_mode_select_o == 2'h3 |=> eoc_n_o; endproperty
    a_eoc_ext: assert property (p_eoc_ext) else $error("eoc low in mode 11");
    // The start pulse is registered, so it answers to the mode of the cycle before
    property p_start;
        conv_start_o |-> $past(clock_mode_select_o) inside {2'h0, 2'h1};
    endproperty
    a_start: assert property (p_start) else $error("start in wrong mode");
    property p_ana; start_pin_is_analog_o == clock_mode_select_o[1]; endproperty
    a_ana: assert property (p_ana) else $error("start pin use wrong");
    property p_idle; cs_n_i [*6] |-> !$rose(cmd_valid_o); endproperty
    a_idle: assert property (p_idle) else $error("byte while deselected");
    property p_mode_rst; $fell(sys_rst_i) |-> clock_mode_select_o == 2'h2; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("reset mode wrong");
endmodule : asp_top_checker
bind asp_top asp_top_checker chk_u (.clk_i, .sys_rst_i, .cs_n_i, .conv_done_i, .dout_oe_n_o,
    .eoc_n_o, .conv_start_o, .clock_mode_select_o, .start_pin_is_analog_o, .cmd_valid_o);

// *** sim/asp_top_bench.sv ***
// Self-checking bench for the converter serial pin top level
`timescale 1ns/100ps
module asp_top_bench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n, sclk, din, dout, oe_n, eoc_n, start, ana, ref_ana, ovr, valid;
    logic cnv_n = 1'b1, done = 1'b0, rdy = 1'b0, ovr_seen = 1'b0, st_seen = 1'b0;
    logic [7:0] tx = 8'h00, rx, cmd;
    logic [1:0] mode;
    int miscompares = 0, compares = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ovr === 1'b1) ovr_seen <= 1'b1;
        if (start === 1'b1) st_seen <= 1'b1;
        if (cycles == 30000) begin
            miscompares++;
            summarize();
        end
    end
    asp_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout));
    asp_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .dout_o(dout), .dout_oe_n_o(oe_n), .convert_request_n_i(cnv_n),
        .eoc_n_o(eoc_n), .tx_data_i(tx), .conv_done_i(done), .conv_start_o(start),
        .clock_mode_select_o(mode), .start_pin_is_analog_o(ana),
        .ref_neg_is_analog_o(ref_ana), .overrun_o(ovr), .cmd_data_o(cmd),
        .cmd_valid_o(valid), .cmd_ready_i(rdy));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pop(output logic [7:0] b);
        b = 8'hee;
        for (int i = 0; i < 40 && valid !== 1'b1; i++) @(negedge clk_i);
        if (valid === 1'b1) b = cmd;
        @(posedge clk_i) rdy <= 1'b1;
        @(posedge clk_i) rdy <= 1'b0;
        @(negedge clk_i);
    endtask : pop
    task automatic drain;
        while (valid === 1'b1) pop(rx);
    endtask : drain
    task automatic pulse_done;
        @(posedge clk_i) done <= 1'b1;
        @(posedge clk_i) done <= 1'b0;
        @(negedge clk_i);
    endtask : pulse_done
    task automatic t_shift;
        @(posedge clk_i) tx <= 8'ha5;
        host_u.xfer(8'h3c, 8, rx);
        chk(rx, 8'ha5);
        pop(rx);
        chk(rx, 8'h3c);
        chk({7'h0, oe_n}, 8'h01);
        // Unfinished byte must not shift the next one
        host_u.xfer(8'hff, 3, rx);
        host_u.xfer(8'h96, 8, rx);
        pop(rx);
        chk(rx, 8'h96);
        $display("t_shift done");
    endtask : t_shift
    task automatic t_setup;
        host_u.xfer(8'h4c, 8, rx);
        drain();
        chk({4'h0, mode, ana, ref_ana}, 8'h00);
        chk({7'h0, ref_ana}, 8'h00);
        @(posedge clk_i) cnv_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        cnv_n <= 1'b1;
        chk({7'h0, st_seen}, 8'h01);
        pulse_done();
        chk({7'h0, eoc_n}, 8'h00);
        host_u.xfer(8'h70, 8, rx);
        drain();
        chk({4'h0, mode, ana, eoc_n}, 8'h0f);
        chk({7'h0, ref_ana}, 8'h01);
        pulse_done();
        chk({7'h0, eoc_n}, 8'h01);
        // Mode 01 turns the start pin back into a request input
        host_u.xfer(8'h50, 8, rx);
        drain();
        chk({4'h0, mode, ana, ref_ana}, 8'h05);
        $display("t_setup done");
    endtask : t_setup
    task automatic t_fifo;
        for (int i = 0; i < 7; i++) host_u.xfer(8'h80 + 8'(i), 8, rx);
        chk({7'h0, ovr_seen}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            pop(rx);
            chk(rx, 8'h80 + 8'(i));
        end
        drain();
        $display("t_fifo done");
    endtask : t_fifo
    task automatic summarize;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk({4'h0, mode, oe_n, eoc_n}, 8'h0b);
        chk({7'h0, ana}, 8'h01);
        chk({7'h0, ref_ana}, 8'h01);
        t_shift();
        t_setup();
        t_fifo();
        summarize();
    end
endmodule : asp_top_bench
